// [design/program_space_table_access.sv]
// table read and write unit between core data path and program memory
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - 24-bit program address, fetch or table
// - pc steps two per program word
// - user reach limited to 000000h-7fffffh
// - low word and high byte spaces
// - upper byte only via high table ops
// - byte and word variants for all
// - low word read returns p15:0
// - low byte read picks byte by select
// - high word read zero fills d15:8
// - high byte read phantom returns zero
// - page register bit 7 picks space
// - config space read only, writes refused
module program_space_table_access #(
  parameter int MEM_AW = 10,                 // implemented user words (log2)
  parameter logic [23:0] CFG_ID0 = 24'h00a5c3, // arbitrary id value
  parameter logic [23:0] CFG_ID1 = 24'h000001  // arbitrary revision value
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // page register load from core
  input wire logic i_page_wr,
  input wire logic [7:0] i_page_wdata,
  // table request
  input wire logic i_tbl_valid,
  input wire table_access_pkg::table_req_s i_tbl_req,
  // instruction fetch
  input wire logic i_fetch_valid,
  input wire logic [23:0] i_fetch_pc,
  // table answers
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  output logic o_wr_done,
  output logic o_wr_refused,
  output logic [7:0] o_page,
  // fetch answers
  output logic o_fetch_valid,
  output logic o_fetch_err,
  output logic [23:0] o_fetch_word
);

  // ==========================================================
  // page register and request decode
  logic [7:0] page_q;         // table_page_select
  logic cfg_sel;              // request aims at config space
  logic is_write;             // request is a table write
  logic bsel;                 // byte select
  logic [14:0] word_idx;      // word index inside a page
  logic [23:0] tbl_addr;      // full 24-bit table address
  logic [23:0] mem_wdata;
  logic [2:0] byte_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [23:0] mem_rdata;
  logic fetch_take;

  // the core loads the page; reads back on o_page
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      page_q <= table_access_pkg::PAGE_RST;
    end else if (i_page_wr) begin
      page_q <= i_page_wdata;
    end
  end

  assign cfg_sel = page_q[table_access_pkg::PAGE_CFG_BIT];
  assign is_write = i_tbl_req.op[1];
  assign bsel = i_tbl_req.addr[table_access_pkg::BSEL_BIT];
  assign word_idx = i_tbl_req.addr[15:1];
  assign tbl_addr = {page_q, i_tbl_req.addr};
  // fetch only uses the port when no table access wants it
  assign fetch_take = i_fetch_valid && !i_tbl_valid;

  // ==========================================================
  // write lane steering
  always_comb begin
    byte_we = 3'h0;
    mem_wdata = {i_tbl_req.wdata[7:0], i_tbl_req.wdata};
    if (i_tbl_valid && is_write && !cfg_sel) begin
      case (i_tbl_req.op)
        table_access_pkg::OP_WT_LOW: begin
          if (!i_tbl_req.byte_mode) begin
            byte_we = 3'h3;
          end else if (bsel) begin
            byte_we = 3'h2;
            mem_wdata[15:8] = i_tbl_req.wdata[7:0];
          end else begin
            byte_we = 3'h1;
          end
        end
        table_access_pkg::OP_WT_HIGH: begin
          // phantom byte writes are dropped
          byte_we = (i_tbl_req.byte_mode && bsel) ? 3'h0 : 3'h4;
        end
        default: begin
          byte_we = 3'h0;
        end
      endcase
    end
  end

  // shared port address: table first, else fetch word index
  always_comb begin
    if (i_tbl_valid) begin
      mem_addr = word_idx[MEM_AW-1:0];
    end else begin
      mem_addr = i_fetch_pc[MEM_AW:1];
    end
  end

  // single-port store; write data lanes arranged above
  prog_word_mem #(
    .AW(MEM_AW),
    .NBYTES(3)
  ) u_mem (
    .i_clk(i_clk),
    .i_addr(mem_addr),
    .i_byte_we(byte_we),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  // ==========================================================
  // stage one: remember what the memory read was for
  logic s1_rd_q;
  logic s1_cfg_q;
  logic s1_fetch_q;
  table_access_pkg::table_op_e s1_op_q;
  logic s1_byte_q;
  logic s1_bsel_q;
  logic [23:0] s1_cfg_word_q;
  logic [23:0] src_word;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s1_rd_q <= 1'b0;
      s1_fetch_q <= 1'b0;
      s1_cfg_q <= 1'b0;
      s1_op_q <= table_access_pkg::OP_RD_LOW;
      s1_byte_q <= 1'b0;
      s1_bsel_q <= 1'b0;
    end else begin
      s1_rd_q <= i_tbl_valid && !is_write;
      s1_fetch_q <= fetch_take;
      s1_cfg_q <= cfg_sel;
      s1_op_q <= i_tbl_req.op;
      s1_byte_q <= i_tbl_req.byte_mode;
      s1_bsel_q <= bsel;
    end
  end

  // config reads only in implemented id words
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s1_cfg_word_q <= table_access_pkg::WORD_RST;
    end else if (word_idx == table_access_pkg::CFG_ID0_IDX) begin
      s1_cfg_word_q <= CFG_ID0;
    end else if (word_idx == table_access_pkg::CFG_ID1_IDX) begin
      s1_cfg_word_q <= CFG_ID1;
    end else begin
      s1_cfg_word_q <= table_access_pkg::WORD_RST;
    end
  end

  assign src_word = s1_cfg_q ? s1_cfg_word_q : mem_rdata;

  // ==========================================================
  // stage two: format the read data onto the data side
  logic [15:0] rd_fmt;

  always_comb begin
    rd_fmt = table_access_pkg::DATA_RST;
    if (s1_op_q == table_access_pkg::OP_RD_LOW) begin
      if (!s1_byte_q) begin
        rd_fmt = src_word[15:0];
      end else begin
        rd_fmt[7:0] = s1_bsel_q ? src_word[15:8] : src_word[7:0];
      end
    end else if (!s1_byte_q) begin
      rd_fmt = {table_access_pkg::PHANTOM_BYTE, src_word[23:16]};
    end else begin
      rd_fmt[7:0] = s1_bsel_q ? table_access_pkg::PHANTOM_BYTE
                              : src_word[23:16];
    end
  end

  // read answer two edges after the request was taken
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= table_access_pkg::DATA_RST;
    end else begin
      o_rd_valid <= s1_rd_q;
      o_rd_data <= s1_rd_q ? rd_fmt : o_rd_data;
    end
  end

  // write answers; a refused write touches no lane
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_wr_done <= 1'b0;
      o_wr_refused <= 1'b0;
    end else begin
      o_wr_done <= i_tbl_valid && is_write && !cfg_sel;
      o_wr_refused <= i_tbl_valid && is_write && cfg_sel;
    end
  end

  assign o_page = page_q;

  // fetch answers; upper half of the space is out of user reach
  logic fetch_err_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fetch_err_q <= 1'b0;
      o_fetch_valid <= 1'b0;
      o_fetch_err <= 1'b0;
      o_fetch_word <= table_access_pkg::WORD_RST;
    end else begin
      fetch_err_q <= i_fetch_pc[table_access_pkg::USER_TOP_BIT];
      o_fetch_valid <= s1_fetch_q && !fetch_err_q;
      o_fetch_err <= s1_fetch_q && fetch_err_q;
      o_fetch_word <= (s1_fetch_q && !fetch_err_q) ? mem_rdata : o_fetch_word;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_rdl_word: assert property (
    s1_rd_q && !s1_cfg_q && s1_op_q == table_access_pkg::OP_RD_LOW
    && !s1_byte_q |=> o_rd_valid && o_rd_data == $past(mem_rdata[15:0]))
    else $error("low word read data wrong");

  a_rdl_byte: assert property (
    s1_rd_q && s1_op_q == table_access_pkg::OP_RD_LOW && s1_byte_q
    |=> o_rd_data[15:8] == 8'h00 && o_rd_data[7:0] == ($past(s1_bsel_q)
    ? $past(src_word[15:8]) : $past(src_word[7:0])))
    else $error("low byte read picked wrong byte");

  a_rdh_word: assert property (
    s1_rd_q && s1_op_q == table_access_pkg::OP_RD_HIGH && !s1_byte_q
    |=> o_rd_data == {8'h00, $past(src_word[23:16])})
    else $error("high word read not zero filled");

  a_rdh_phantom: assert property (
    s1_rd_q && s1_op_q == table_access_pkg::OP_RD_HIGH && s1_byte_q
    && s1_bsel_q |=> o_rd_data == 16'h0000)
    else $error("phantom byte not zero");

  a_cfg_wr_blocked: assert property (
    i_tbl_valid && is_write && cfg_sel
    |-> byte_we == 3'h0 ##1 o_wr_refused && !o_wr_done)
    else $error("config write not refused");

  a_low_no_upper: assert property (
    i_tbl_valid && i_tbl_req.op == table_access_pkg::OP_WT_LOW
    |-> !byte_we[2])
    else $error("low write touched upper byte");

  a_rd_latency: assert property (
    i_tbl_valid && !is_write |-> ##2 o_rd_valid)
    else $error("read answer not two edges later");

  a_fetch_user: assert property (
    fetch_take && i_fetch_pc[23] |-> ##2 o_fetch_err && !o_fetch_valid)
    else $error("fetch above user half not refused");

  a_page_space: assert property (
    i_tbl_valid && tbl_addr[table_access_pkg::USER_TOP_BIT]
    && i_tbl_req.op == table_access_pkg::OP_RD_LOW && !i_tbl_req.byte_mode
    && word_idx == table_access_pkg::CFG_ID0_IDX
    |-> ##2 o_rd_data == CFG_ID0[15:0])
    else $error("config page does not reach id word");

  a_word_step: assert property (
    i_tbl_valid |-> mem_addr == i_tbl_req.addr[MEM_AW:1])
    else $error("word index not address over two");

endmodule
`default_nettype wire

// [design/table_access_pkg.sv]
// shared types and constants for the program space table access unit
`default_nettype none
package table_access_pkg;

  // ==========================================================
  // address layout
  localparam int PROG_ADDR_W = 24;     // program address width
  localparam int PC_W = 23;            // program counter width
  localparam int WORD_W = 24;          // program word width
  localparam int DATA_W = 16;          // data side width
  localparam int PAGE_W = 8;           // table page register width
  localparam int PAGE_CFG_BIT = 7;     // page bit selecting config space
  localparam int BSEL_BIT = 0;         // data address bit used as byte select
  localparam int USER_TOP_BIT = 23;    // set only above 7fffff

  // ==========================================================
  // values after reset
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [23:0] WORD_RST = 24'h000000;
  localparam logic [7:0] PHANTOM_BYTE = 8'h00;

  // ==========================================================
  // configuration space identification words (word index in config page)
  localparam logic [14:0] CFG_ID0_IDX = 15'h0000;
  localparam logic [14:0] CFG_ID1_IDX = 15'h0001;

  // ==========================================================
  // table operations
  typedef enum logic [1:0] {
    OP_RD_LOW = 2'h0,  // table_read_low_word
    OP_RD_HIGH = 2'h1, // table_read_high_word
    OP_WT_HIGH = 2'h3, // table_write_high_word
    OP_WT_LOW = 2'h2   // table_write_low_word
  } table_op_e;

  // one table request from the core
  typedef struct packed {
    table_op_e op;           // which table operation
    logic byte_mode;         // 1 = byte transfer, 0 = word
    logic [15:0] addr;       // effective data side address
    logic [15:0] wdata;      // write data
  } table_req_s;

endpackage
`default_nettype wire

// [design/prog_word_mem.sv]
// program word memory with per-byte write enables and registered read
`timescale 1ns/1ps
`default_nettype none
module prog_word_mem #(
  parameter int AW = 10,
  parameter int NBYTES = 3
) (
  // clock
  input wire logic i_clk,
  // access port
  input wire logic [AW-1:0] i_addr,
  input wire logic [NBYTES-1:0] i_byte_we,
  input wire logic [NBYTES*8-1:0] i_wdata,
  output logic [NBYTES*8-1:0] o_rdata
);

  // ==========================================================
  // storage, one array per program byte lane
  for (genvar b = 0; b < NBYTES; b++) begin : g_lane
    logic [7:0] lane_q [2**AW]; // one byte of every word
    logic [7:0] rd_q;           // registered lane read

    // each lane owns its array, so one process writes it and
    // partial words keep their other bytes intact
    always_ff @(posedge i_clk) begin
      if (i_byte_we[b]) begin
        lane_q[i_addr] <= i_wdata[b*8 +: 8];
      end
    end

    // read data always comes out of a register
    always_ff @(posedge i_clk) begin
      rd_q <= lane_q[i_addr];
    end

    assign o_rdata[b*8 +: 8] = rd_q;
  end

endmodule
`default_nettype wire

// [verif/core_req_model.sv]
// core side model that issues page, table and fetch requests
`timescale 1ns/1ps
`default_nettype none
module core_req_model (
  // clock
  input wire logic i_clk,
  // requests towards the table unit
  output logic o_page_wr,
  output logic [7:0] o_page_wdata,
  output logic o_tbl_valid,
  output table_access_pkg::table_req_s o_tbl_req,
  output logic o_fetch_valid,
  output logic [23:0] o_fetch_pc
);
  // ====
  // idle values at time zero
  initial begin
    o_page_wr = 1'b0;
    o_page_wdata = 8'h00;
    o_tbl_valid = 1'b0;
    o_tbl_req = '0;
    o_fetch_valid = 1'b0;
    o_fetch_pc = 24'h000000;
  end
  // one request for one edge; fields inverted after, so stale data is no help
  // byte select rides in addr bit 0
  task automatic tbl(input table_access_pkg::table_op_e op, input logic bm,
                     input logic [15:0] addr, input logic [15:0] wd);
    @(negedge i_clk);
    o_tbl_req = '{op: op, byte_mode: bm, addr: addr, wdata: wd};
    o_tbl_valid = 1'b1;
    @(negedge i_clk);
    o_tbl_valid = 1'b0;
    o_tbl_req = ~o_tbl_req;
  endtask
  // page register load, one edge
  task automatic page(input logic [7:0] v);
    @(negedge i_clk);
    o_page_wdata = v;
    o_page_wr = 1'b1;
    @(negedge i_clk);
    o_page_wr = 1'b0;
    o_page_wdata = ~v;
  endtask
  // instruction fetch, one edge
  task automatic fetch(input logic [23:0] pc);
    @(negedge i_clk);
    o_fetch_pc = pc;
    o_fetch_valid = 1'b1;
    @(negedge i_clk);
    o_fetch_valid = 1'b0;
    o_fetch_pc = ~pc;
  endtask
endmodule
`default_nettype wire

// [verif/program_space_table_access_tb_top.sv]
// self-checking bench for the table access unit
`timescale 1ns/1ps
`default_nettype none
module program_space_table_access_tb_top;
  localparam logic [23:0] ID0 = 24'h3c5a96; // arbitrary id value
  localparam logic [23:0] ID1 = 24'h7e0002; // arbitrary revision value
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic page_wr, tbl_valid, fetch_valid;
  logic [7:0] page_wdata, page;
  logic [23:0] fetch_pc, fetch_word;
  table_access_pkg::table_req_s tbl_req;
  logic rd_valid, wr_done, wr_refused, f_valid, f_err;
  logic [15:0] rd_data;
  int n_fail = 0;
  int checked = 0;
  // ====
  // clock and the two parties
  always #25 clk = ~clk;
  core_req_model core_u (.i_clk(clk), .o_page_wr(page_wr),
    .o_page_wdata(page_wdata), .o_tbl_valid(tbl_valid), .o_tbl_req(tbl_req),
    .o_fetch_valid(fetch_valid), .o_fetch_pc(fetch_pc));
  program_space_table_access #(.MEM_AW(10), .CFG_ID0(ID0), .CFG_ID1(ID1))
    dut_u (.i_clk(clk), .i_sys_rst(sys_rst), .i_page_wr(page_wr),
    .i_page_wdata(page_wdata), .i_tbl_valid(tbl_valid), .i_tbl_req(tbl_req),
    .i_fetch_valid(fetch_valid), .i_fetch_pc(fetch_pc), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_wr_done(wr_done), .o_wr_refused(wr_refused),
    .o_page(page), .o_fetch_valid(f_valid), .o_fetch_err(f_err),
    .o_fetch_word(fetch_word));
  // ====
  // compare tasks, one per kind of result
  task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // read: answer lands after the second edge, pulse checked in its cycle
  task automatic rd(input table_access_pkg::table_op_e op, input logic bm,
                    input logic [15:0] addr, input logic [15:0] exp);
    core_u.tbl(op, bm, addr, 16'h0000);
    chk_f(rd_valid, 1'b0);
    @(negedge clk);
    chk_f(rd_valid, 1'b1);
    chk_v({8'h00, rd_data}, {8'h00, exp});
  endtask
  // write: done or refused in the cycle after, for one cycle only
  task automatic wr(input table_access_pkg::table_op_e op, input logic bm,
                    input logic [15:0] addr, input logic [15:0] wd,
                    input logic refused);
    core_u.tbl(op, bm, addr, wd);
    chk_f(wr_done, ~refused);
    chk_f(wr_refused, refused);
    @(negedge clk);
    chk_f(wr_done, 1'b0);
    chk_f(wr_refused, 1'b0);
  endtask
  // ====
  // scenarios
  task automatic t_user;
    wr(table_access_pkg::OP_WT_LOW, 1'b0, 16'h0010, 16'hbeef, 1'b0);
    wr(table_access_pkg::OP_WT_HIGH, 1'b0, 16'h0010, 16'h0012, 1'b0);
    rd(table_access_pkg::OP_RD_LOW, 1'b0, 16'h0010, 16'hbeef);
    rd(table_access_pkg::OP_RD_HIGH, 1'b0, 16'h0010, 16'h0012);
    rd(table_access_pkg::OP_RD_LOW, 1'b1, 16'h0010, 16'h00ef);
    rd(table_access_pkg::OP_RD_LOW, 1'b1, 16'h0011, 16'h00be);
    rd(table_access_pkg::OP_RD_HIGH, 1'b1, 16'h0010, 16'h0012);
    rd(table_access_pkg::OP_RD_HIGH, 1'b1, 16'h0011, 16'h0000);
    wr(table_access_pkg::OP_WT_LOW, 1'b1, 16'h0011, 16'h005a, 1'b0);
    rd(table_access_pkg::OP_RD_LOW, 1'b0, 16'h0010, 16'h5aef);
    // phantom byte write is accepted but changes nothing
    wr(table_access_pkg::OP_WT_HIGH, 1'b1, 16'h0011, 16'h0077, 1'b0);
    rd(table_access_pkg::OP_RD_HIGH, 1'b0, 16'h0010, 16'h0012);
  endtask
  task automatic t_config;
    core_u.page(8'h80);
    chk_v({16'h0000, page}, 24'h000080);
    // a write aimed at the word also used in user space must be refused
    wr(table_access_pkg::OP_WT_LOW, 1'b0, 16'h0010, 16'h1111, 1'b1);
    rd(table_access_pkg::OP_RD_LOW, 1'b0, 16'h0000, ID0[15:0]);
    rd(table_access_pkg::OP_RD_HIGH, 1'b0, 16'h0002,
       {8'h00, ID1[23:16]});
    rd(table_access_pkg::OP_RD_LOW, 1'b0, 16'h0010, 16'h0000);
    core_u.page(8'h00);
    rd(table_access_pkg::OP_RD_LOW, 1'b0, 16'h0010, 16'h5aef);
  endtask
  task automatic t_fetch;
    // word index 8 sits at pc 000010h because pc steps two per word
    core_u.fetch(24'h000010);
    @(negedge clk);
    chk_f(f_valid, 1'b1);
    chk_v(fetch_word, 24'h125aef);
    core_u.fetch(24'h800010);
    @(negedge clk);
    chk_f(f_err, 1'b1);
    chk_f(f_valid, 1'b0);
  endtask
  // table access wins the port; the fetch of that cycle gets no answer
  task automatic t_clash;
    fork
      rd(table_access_pkg::OP_RD_LOW, 1'b0, 16'h0010, 16'h5aef);
      core_u.fetch(24'h000010);
    join
    chk_f(f_valid | f_err, 1'b0);
  endtask
  // ====
  // closing report, the only place the run ends
  task automatic test_done;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // main sequence: reset held eight cycles, outputs idle meanwhile
  initial begin
    repeat (8) @(negedge clk);
    chk_v({page, 15'h0000, rd_valid}, 24'h000000);
    chk_v({rd_data, page}, 24'h000000);
    chk_v(fetch_word, 24'h000000);
    chk_f(wr_done | wr_refused | f_valid | f_err, 1'b0);
    sys_rst = 1'b0;
    t_user();
    t_config();
    t_fetch();
    t_clash();
    test_done();
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    $display("mismatch at %0t: run did not finish", $time);
    test_done();
  end
endmodule
`default_nettype wire
